/* core/mact_map.svh */
`ifndef MACT_MAP_SVH
`define MACT_MAP_SVH

// ==========================================================
// widths
`define MACT_OP_W 5
`define MACT_BASE_W 7
`define MACT_TOTAL_W 10
`define MACT_CNT_W 5
`define MACT_EA_W 8
`define MACT_MULT_W 3

// ==========================================================
// limits and reset values
`define MACT_MAX_REGS 5'h10
`define MACT_OP_COUNT 5'h1e
`define MACT_TOTAL_RST 10'h000
`define MACT_CNT_RST 5'h00

// ==========================================================
// prefetches a worst-case figure carries
`define MACT_WORST_PF 2'h1
`define MACT_WORST_PF_STATUS 2'h2

`endif

/* core/mact_pkg.sv */
`include "mact_map.svh"

package mact_pkg;

  // ==========================================================
  // instruction groups sharing one timing row
  typedef enum logic [`MACT_OP_W-1:0] {
    op_exchange = 5'h00,
    op_ctrl_to_reg = 5'h01,
    op_reg_to_ctrl = 5'h02,
    op_status_to_reg = 5'h03,
    op_status_to_mem = 5'h04,
    op_ea_to_flags = 5'h05,
    op_ea_to_status = 5'h06,
    op_multi_load = 5'h07,
    op_multi_store = 5'h08,
    op_periph_word_out = 5'h09,
    op_periph_long_out = 5'h0a,
    op_periph_word_in = 5'h0b,
    op_periph_long_in = 5'h0c,
    op_alt_load = 5'h0d,
    op_alt_store = 5'h0e,
    op_user_stack = 5'h0f,
    op_swap_halves = 5'h10,
    op_alu_to_reg = 5'h11,
    op_alu_to_mem = 5'h12,
    op_cmp_addr = 5'h13,
    op_cmp_bounds = 5'h14,
    op_mul_word = 5'h15,
    op_long_multiply = 5'h16,
    op_divu_word = 5'h17,
    op_divu_long = 5'h18,
    op_divs_word = 5'h19,
    op_signed_long_divide = 5'h1a,
    op_quick_reg = 5'h1b,
    op_quick_mem = 5'h1c,
    op_imm_reg = 5'h1d,
    op_imm_mem = 5'h1e
  } mact_op_e;

  typedef enum logic [1:0] {
    speed_best = 2'b00,
    speed_cache = 2'b01,
    speed_worst = 2'b10
  } mact_speed_e;

  // which address time is added on top of the listed count
  typedef enum logic [2:0] {
    add_none = 3'b000,
    add_fetch_ea = 3'b001,
    add_calc_ea = 3'b010,
    add_calc_imm = 3'b011,
    add_fetch_imm = 3'b100
  } mact_add_e;

  typedef struct packed {
    logic [`MACT_BASE_W-1:0] best;
    logic [`MACT_BASE_W-1:0] cache;
    logic [`MACT_BASE_W-1:0] worst;
    logic [2:0] reads;
    logic [2:0] writes;
    logic [`MACT_MULT_W-1:0] per_reg;
    logic n_reads;
    logic n_writes;
    logic [1:0] worst_pf;
    mact_add_e add;
  } mact_row_s;

endpackage

/* core/mact_if.sv */
`include "mact_map.svh"

interface mact_if;
  mact_pkg::mact_op_e op;
  mact_pkg::mact_row_s row;
  logic legal;

  modport table_side (input op, output row, output legal);
  modport ctrl_side (output op, input row, input legal);
endinterface

/* core/mact_table.sv */
`include "mact_map.svh"

module mact_table (
  mact_if.table_side lk
);

  // ==========================================================
  // timing rows: best, cache, worst, reads, writes, per-register clocks
  always_comb begin
    lk.legal = 1'b1;
    lk.row = '{7'h00, 7'h02, 7'h03, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
      `MACT_WORST_PF, mact_pkg::add_none};
    unique case (lk.op)
      mact_pkg::op_exchange, mact_pkg::op_user_stack, mact_pkg::op_quick_reg: begin
        lk.row.add = mact_pkg::add_none;
      end
      mact_pkg::op_ctrl_to_reg: begin
        lk.row = '{7'h03, 7'h06, 7'h07, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_reg_to_ctrl: begin
        lk.row = '{7'h09, 7'h0c, 7'h0d, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_status_to_reg: begin
        lk.row = '{7'h01, 7'h04, 7'h05, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_status_to_mem: begin
        lk.row = '{7'h05, 7'h05, 7'h07, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_calc_ea};
      end
      mact_pkg::op_ea_to_flags: begin
        lk.row = '{7'h04, 7'h04, 7'h05, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_ea};
      end
      mact_pkg::op_ea_to_status: begin
        lk.row = '{7'h08, 7'h08, 7'h0b, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF_STATUS, mact_pkg::add_fetch_ea};
      end
      mact_pkg::op_multi_load: begin
        lk.row = '{7'h08, 7'h08, 7'h09, 3'h0, 3'h0, 3'h4, 1'b1, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_calc_imm};
      end
      mact_pkg::op_multi_store: begin
        lk.row = '{7'h04, 7'h04, 7'h05, 3'h0, 3'h0, 3'h3, 1'b0, 1'b1,
          `MACT_WORST_PF, mact_pkg::add_calc_imm};
      end
      mact_pkg::op_periph_word_out: begin
        lk.row = '{7'h08, 7'h0b, 7'h0b, 3'h0, 3'h2, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_periph_long_out: begin
        lk.row = '{7'h0e, 7'h11, 7'h11, 3'h0, 3'h4, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_periph_word_in: begin
        lk.row = '{7'h0a, 7'h0c, 7'h0c, 3'h2, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_periph_long_in: begin
        lk.row = '{7'h10, 7'h12, 7'h12, 3'h4, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
      end
      mact_pkg::op_alt_load: begin
        lk.row = '{7'h07, 7'h07, 7'h08, 3'h1, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_calc_imm};
      end
      mact_pkg::op_alt_store: begin
        lk.row = '{7'h05, 7'h05, 7'h07, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_calc_imm};
      end
      mact_pkg::op_swap_halves, mact_pkg::op_cmp_addr: begin
        lk.row = '{7'h01, 7'h04, 7'h04, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_none};
        if (lk.op == mact_pkg::op_cmp_addr) begin
          lk.row.add = mact_pkg::add_fetch_ea;
        end
      end
      mact_pkg::op_alu_to_reg: begin
        lk.row.add = mact_pkg::add_fetch_ea;
      end
      mact_pkg::op_alu_to_mem, mact_pkg::op_quick_mem, mact_pkg::op_imm_mem: begin
        lk.row = '{7'h03, 7'h04, 7'h06, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_ea};
        if (lk.op == mact_pkg::op_imm_mem) begin
          lk.row.add = mact_pkg::add_fetch_imm;
        end
      end
      mact_pkg::op_cmp_bounds: begin
        lk.row = '{7'h10, 7'h12, 7'h12, 3'h1, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_imm};
      end
      mact_pkg::op_mul_word: begin
        lk.row = '{7'h19, 7'h1b, 7'h1c, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_ea};
      end
      mact_pkg::op_long_multiply: begin
        lk.row = '{7'h29, 7'h2b, 7'h2c, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_imm};
      end
      mact_pkg::op_divu_word: begin
        lk.row = '{7'h2a, 7'h2c, 7'h2c, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_ea};
      end
      mact_pkg::op_divu_long: begin
        lk.row = '{7'h4c, 7'h4e, 7'h4f, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_imm};
      end
      mact_pkg::op_divs_word: begin
        lk.row = '{7'h36, 7'h38, 7'h39, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_ea};
      end
      mact_pkg::op_signed_long_divide: begin
        lk.row = '{7'h58, 7'h5a, 7'h5b, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0,
          `MACT_WORST_PF, mact_pkg::add_fetch_imm};
      end
      mact_pkg::op_imm_reg: begin
        lk.row.add = mact_pkg::add_fetch_imm;
      end
      default: begin
        // codes above the last group carry no timing
        lk.legal = 1'b0;
      end
    endcase
  end

endmodule

/* core/mact_core.sv */
`include "mact_map.svh"

// Function
// - totals count every clock; read/prefetch/write counts lie inside the total
// - worst-case arithmetic figures carry one extra prefetch for the next instruction
// - multi load 8+4n (worst 9+4n) with n reads; store 4+3n (5+3n)
// - single-asterisk groups add the operand fetch address time
// - dagger groups such as status store add address calculation time
// - multi-register and alternate-space alternate_space_move add immediate address calculation time
// - double-asterisk groups add immediate operand fetch address time
// - register to control register: 9, 12, 13 clocks, no operand cycles
// - status load: 8 best and cache, 11 worst with two prefetches
// - long multiply: 41, 43, 44 clocks, worst adds one prefetch
// - signed long divide: 88, 90, 91 clocks, worst adds one prefetch
// - alternate-space load: 7 with one read, worst 8 plus prefetch
module mact_core (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire mact_pkg::mact_op_e op,
  input wire logic prefetched,
  input wire logic cache_hit,
  input wire logic [`MACT_CNT_W-1:0] reg_count,
  input wire logic [`MACT_EA_W-1:0] fetch_ea_time,
  input wire logic [`MACT_EA_W-1:0] calc_ea_time,
  input wire logic [`MACT_EA_W-1:0] calc_imm_time,
  input wire logic [`MACT_EA_W-1:0] fetch_imm_time,
  output logic busy,
  output logic done,
  output logic error,
  output mact_pkg::mact_speed_e speed,
  output mact_pkg::mact_add_e add_kind,
  output logic [`MACT_TOTAL_W-1:0] total_clocks,
  output logic [`MACT_TOTAL_W-1:0] remaining,
  output logic [`MACT_CNT_W-1:0] read_cycles,
  output logic [`MACT_CNT_W-1:0] prefetch_cycles,
  output logic [`MACT_CNT_W-1:0] write_cycles
);

  // ==========================================================
  // state
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_eval = 2'b01,
    st_run = 2'b10,
    st_end = 2'b11
  } mact_state_e;

  mact_state_e state;
  mact_pkg::mact_op_e op_hold;
  mact_pkg::mact_speed_e speed_hold;
  logic [`MACT_CNT_W-1:0] n_hold;
  logic [`MACT_EA_W-1:0] ea_hold [4];
  logic bad_count;
  mact_pkg::mact_speed_e next_speed;
  logic [`MACT_BASE_W-1:0] base_pick;
  logic [`MACT_TOTAL_W-1:0] per_reg_clocks;
  logic [`MACT_EA_W-1:0] addr_time;
  logic [`MACT_TOTAL_W-1:0] next_total;
  logic [`MACT_CNT_W-1:0] next_reads;
  logic [`MACT_CNT_W-1:0] next_writes;
  logic [`MACT_CNT_W-1:0] next_pf;
  logic refuse;
  logic stop_now;

  mact_if lk ();

  mact_table u_table (
    .lk(lk.table_side)
  );

  assign lk.op = op_hold;

  // ==========================================================
  // case selection
  always_comb begin
    if (prefetched) begin
      next_speed = mact_pkg::speed_best;
    end else if (cache_hit) begin
      next_speed = mact_pkg::speed_cache;
    end else begin
      next_speed = mact_pkg::speed_worst;
    end
  end

  // ==========================================================
  // figure assembly from the held request
  always_comb begin
    unique case (speed_hold)
      mact_pkg::speed_best: base_pick = lk.row.best;
      mact_pkg::speed_cache: base_pick = lk.row.cache;
      default: base_pick = lk.row.worst;
    endcase
    // both factors widened first so a long register list cannot wrap the product
    per_reg_clocks = `MACT_TOTAL_W'(lk.row.per_reg) * `MACT_TOTAL_W'(n_hold);
    unique case (lk.row.add)
      mact_pkg::add_fetch_ea: addr_time = ea_hold[0];
      mact_pkg::add_calc_ea: addr_time = ea_hold[1];
      mact_pkg::add_calc_imm: addr_time = ea_hold[2];
      mact_pkg::add_fetch_imm: addr_time = ea_hold[3];
      default: addr_time = `MACT_EA_W'(0);
    endcase
    next_total = `MACT_TOTAL_W'(base_pick) + per_reg_clocks
      + `MACT_TOTAL_W'(addr_time);
  end

  // ==========================================================
  // bus cycle triple
  always_comb begin
    next_reads = `MACT_CNT_W'(lk.row.reads) + (lk.row.n_reads ? n_hold : `MACT_CNT_RST);
    next_writes = `MACT_CNT_W'(lk.row.writes) + (lk.row.n_writes ? n_hold : `MACT_CNT_RST);
    // only a bus fetch of the next instruction shows up as prefetch
    next_pf = (speed_hold == mact_pkg::speed_worst) ?
      `MACT_CNT_W'(lk.row.worst_pf) : `MACT_CNT_RST;
  end

  // ==========================================================
  // refusal and early finish, both settled in the evaluate cycle
  always_comb begin
    refuse = !lk.legal || bad_count;
    // a zero-length figure finishes at once instead of counting through zero
    stop_now = refuse || next_total == `MACT_TOTAL_RST;
  end

  // ==========================================================
  // request capture
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      op_hold <= mact_pkg::op_exchange;
      speed_hold <= mact_pkg::speed_worst;
      n_hold <= `MACT_CNT_RST;
      bad_count <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        ea_hold[i] <= `MACT_EA_W'(0);
      end
    end else if (state == st_idle && start) begin
      op_hold <= op;
      speed_hold <= next_speed;
      // only register-list alternate_space_move use the count; others ignore it
      n_hold <= reg_count;
      bad_count <= (reg_count > `MACT_MAX_REGS)
        && (op == mact_pkg::op_multi_load || op == mact_pkg::op_multi_store);
      ea_hold[0] <= fetch_ea_time;
      ea_hold[1] <= calc_ea_time;
      ea_hold[2] <= calc_imm_time;
      ea_hold[3] <= fetch_imm_time;
    end
  end

  // ==========================================================
  // sequencing: one cycle to evaluate, then total_clocks cycles of run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= st_idle;
    end else begin
      unique case (state)
        st_idle: begin
          if (start) begin
            state <= st_eval;
          end
        end
        st_eval: begin
          if (stop_now) begin
            state <= st_end;
          end else begin
            state <= st_run;
          end
        end
        st_run: begin
          if (remaining == 10'h001) begin
            state <= st_end;
          end
        end
        st_end: state <= st_idle;
      endcase
    end
  end

  // ==========================================================
  // reported figures
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      total_clocks <= `MACT_TOTAL_RST;
      read_cycles <= `MACT_CNT_RST;
      prefetch_cycles <= `MACT_CNT_RST;
      write_cycles <= `MACT_CNT_RST;
      speed <= mact_pkg::speed_best;
      add_kind <= mact_pkg::add_none;
      error <= 1'b0;
    end else if (state == st_eval && refuse) begin
      // illegal requests report zeros so nothing downstream trusts them
      error <= 1'b1;
      total_clocks <= `MACT_TOTAL_RST;
      read_cycles <= `MACT_CNT_RST;
      prefetch_cycles <= `MACT_CNT_RST;
      write_cycles <= `MACT_CNT_RST;
      speed <= speed_hold;
      add_kind <= lk.legal ? lk.row.add : mact_pkg::add_none;
    end else if (state == st_eval) begin
      error <= 1'b0;
      total_clocks <= next_total;
      read_cycles <= next_reads;
      prefetch_cycles <= next_pf;
      write_cycles <= next_writes;
      speed <= speed_hold;
      add_kind <= lk.row.add;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      remaining <= `MACT_TOTAL_RST;
    end else if (state == st_eval) begin
      remaining <= refuse ? `MACT_TOTAL_RST : next_total;
    end else if (state == st_run) begin
      remaining <= remaining - 10'h001;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state == st_idle) ? start : (state != st_end);
      done <= (state == st_run && remaining == 10'h001) || (state == st_eval && stop_now);
    end
  end

endmodule

/* tb/mact_core_asserts.sv */
`include "mact_map.svh"

module mact_core_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic prefetched,
  input wire logic cache_hit,
  input wire logic busy,
  input wire logic done,
  input wire logic error,
  input wire mact_pkg::mact_speed_e speed,
  input wire logic [`MACT_TOTAL_W-1:0] total_clocks,
  input wire logic [`MACT_TOTAL_W-1:0] remaining,
  input wire logic [`MACT_CNT_W-1:0] read_cycles,
  input wire logic [`MACT_CNT_W-1:0] prefetch_cycles,
  input wire logic [`MACT_CNT_W-1:0] write_cycles
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // helpers
  logic [10:0] busy_run;
  mact_pkg::mact_speed_e want_speed;

  // prefetched outranks cache_hit
  assign want_speed = prefetched ? mact_pkg::speed_best :
    (cache_hit ? mact_pkg::speed_cache : mact_pkg::speed_worst);

  // counts busy cycles so the real duration can be held against the reported total
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_run <= 11'h000;
    end else begin
      busy_run <= busy ? busy_run + 11'h001 : 11'h000;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ==========================================================
  // assertions
  a_start_taken: assert property (start && !busy |=> busy)
    else $error("start while idle was not taken");
  a_done_pulse: assert property (done |=> !done && !busy)
    else $error("done not a single pulse ending busy");
  a_count_down: assert property (busy && remaining > 1 |=> remaining == $past(remaining) - 1)
    else $error("remaining did not step down by one");
  a_last_count: assert property (busy && remaining == 1 |=> done && remaining == 0)
    else $error("done did not follow the last count");
  a_run_length: assert property (
    done |-> busy_run == {1'b0, total_clocks} + 11'h001)
    else $error("busy duration differs from total clocks");
  a_triple_inside: assert property (done && !error |->
    ({5'h00, read_cycles} + {5'h00, prefetch_cycles} + {5'h00, write_cycles}) <= total_clocks)
    else $error("bus cycles exceed total clocks");
  a_worst_prefetch: assert property (done && !error |->
    ((speed == mact_pkg::speed_worst) == (prefetch_cycles != 0)) && prefetch_cycles <= 2)
    else $error("prefetch count does not match case");
  a_speed_pick: assert property (
    start && !busy |=> ##1 (error || speed == $past(want_speed, 2)))
    else $error("case not chosen from prefetch and cache inputs");
  a_error_zero: assert property (done && error |->
    total_clocks == 0 && read_cycles == 0 && write_cycles == 0)
    else $error("refused request reported figures");
endmodule

/* tb/mact_core_tb.sv */
`include "mact_map.svh"

module mact_core_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // stimulus and design
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  mact_pkg::mact_op_e op = mact_pkg::op_exchange;
  logic prefetched = 1'b0;
  logic cache_hit = 1'b0;
  logic [`MACT_CNT_W-1:0] reg_count = 5'h00;
  logic [`MACT_EA_W-1:0] ea_t [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic busy, done, error;
  mact_pkg::mact_speed_e speed;
  mact_pkg::mact_add_e add_kind;
  logic [`MACT_TOTAL_W-1:0] total_clocks, remaining;
  logic [`MACT_CNT_W-1:0] read_cycles, prefetch_cycles, write_cycles;
  int failures = 0;
  int total_checks = 0;
  // best, cache, worst clocks, reads, writes and added time kind for every group
  int fig [31][6] = '{
    '{0, 2, 3, 0, 0, 0},
    '{3, 6, 7, 0, 0, 0},
    '{9, 12, 13, 0, 0, 0},
    '{1, 4, 5, 0, 0, 0},
    '{5, 5, 7, 0, 1, 2},
    '{4, 4, 5, 0, 0, 1},
    '{8, 8, 11, 0, 0, 1},
    '{8, 8, 9, 0, 0, 3},
    '{4, 4, 5, 0, 0, 3},
    '{8, 11, 11, 0, 2, 0},
    '{14, 17, 17, 0, 4, 0},
    '{10, 12, 12, 2, 0, 0},
    '{16, 18, 18, 4, 0, 0},
    '{7, 7, 8, 1, 0, 3},
    '{5, 5, 7, 0, 1, 3},
    '{0, 2, 3, 0, 0, 0},
    '{1, 4, 4, 0, 0, 0},
    '{0, 2, 3, 0, 0, 1},
    '{3, 4, 6, 0, 1, 1},
    '{1, 4, 4, 0, 0, 1},
    '{16, 18, 18, 1, 0, 4},
    '{25, 27, 28, 0, 0, 1},
    '{41, 43, 44, 0, 0, 4},
    '{42, 44, 44, 0, 0, 1},
    '{76, 78, 79, 0, 0, 4},
    '{54, 56, 57, 0, 0, 1},
    '{88, 90, 91, 0, 0, 4},
    '{0, 2, 3, 0, 0, 0},
    '{3, 4, 6, 0, 1, 1},
    '{0, 2, 3, 0, 0, 4},
    '{3, 4, 6, 0, 1, 4}
  };

  mact_core dut_u (.clk(clk), .nrst(nrst), .start(start), .op(op), .prefetched(prefetched),
    .cache_hit(cache_hit), .reg_count(reg_count), .fetch_ea_time(ea_t[0]),
    .calc_ea_time(ea_t[1]), .calc_imm_time(ea_t[2]), .fetch_imm_time(ea_t[3]),
    .busy(busy), .done(done), .error(error), .speed(speed), .add_kind(add_kind),
    .total_clocks(total_clocks), .remaining(remaining), .read_cycles(read_cycles),
    .prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles));

  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // checking
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // one request; s is 0 best, 1 cache, 2 worst
  task automatic go(input logic [4:0] o, input int s, input int n);
    int row [6];
    int tot, r, wr, i;
    logic err;
    logic [7:0] tv [4];
    row = fig[(o > 5'h1e) ? 5'h00 : o];
    err = (o > 5'h1e) || (o inside {5'h07, 5'h08} && n > 16);
    r = row[3] + ((o == 5'h07) ? n : 0);
    wr = row[4] + ((o == 5'h08) ? n : 0);
    for (i = 0; i < 4; i++) tv[i] = 8'($urandom);
    tot = row[s] + ((o == 5'h07) ? 4 * n : 0) + ((o == 5'h08) ? 3 * n : 0);
    if (row[5] > 0) tot += tv[row[5] - 1];
    @(posedge clk);
    op <= mact_pkg::mact_op_e'(o);
    prefetched <= (s == 0);
    cache_hit <= (s == 1) || (s == 0 && $urandom_range(1) == 1);
    reg_count <= n[4:0];
    for (i = 0; i < 4; i++) ea_t[i] <= tv[i];
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (i = 0; i < 700; i++) begin
      @(posedge clk);
      // a second request while busy must be ignored
      if (i == 1 && tot > 4) begin
        start <= 1'b1;
        op <= mact_pkg::op_exchange;
      end
      if (i == 2) start <= 1'b0;
      #1;
      if (done === 1'b1) break;
    end
    if (i == 700) begin
      failures++;
      conclude();
    end
    chk(i, err ? 0 : tot);
    chk(error, err);
    if (err) chk(total_clocks, 0);
    else begin
      chk(total_clocks, tot);
      chk(read_cycles, r);
      chk(prefetch_cycles, (s < 2) ? 0 : ((o == 5'h06) ? 2 : 1));
      chk(write_cycles, wr);
      chk(add_kind, row[5]);
      chk(speed, s);
    end
    chk(remaining, 0);
    @(posedge clk);
    #1;
    chk(busy, 0);
    chk(done, 0);
  endtask

  // ==========================================================
  // sequence
  initial begin
    void'($urandom(32'h7344f352));
    repeat (16) @(posedge clk);
    #1;
    chk(busy, 0);
    chk(total_clocks, 0);
    @(posedge clk);
    nrst <= 1'b1;
    for (int o = 0; o < 31; o++) begin
      for (int s = 0; s < 3; s++) go(5'(o), s, 16);
    end
    $display("test table done");
    go(mact_pkg::op_multi_load, 2, 0);
    go(mact_pkg::op_multi_store, 0, 0);
    go(mact_pkg::op_multi_load, 1, 17);
    go(mact_pkg::op_multi_store, 2, 17);
    go(5'h1f, 2, 0);
    $display("test edge done");
    repeat (40) go(5'($urandom_range(30)), $urandom_range(2), $urandom_range(16));
    $display("test random done");
    @(posedge clk);
    op <= mact_pkg::op_signed_long_divide;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    #1;
    chk(busy, 0);
    chk(done, 0);
    chk(remaining, 0);
    chk(total_clocks, 0);
    @(posedge clk);
    nrst <= 1'b1;
    go(mact_pkg::op_reg_to_ctrl, 2, 0);
    $display("test reset done");
    conclude();
  end
endmodule

bind mact_core mact_core_asserts chk_u (.clk(clk), .nrst(nrst), .start(start),
  .prefetched(prefetched), .cache_hit(cache_hit), .busy(busy), .done(done), .error(error),
  .speed(speed), .total_clocks(total_clocks), .remaining(remaining),
  .read_cycles(read_cycles), .prefetch_cycles(prefetch_cycles), .write_cycles(write_cycles));
